// [acmux_pkg.sv]
// package for the single amplifier control and input multiplexer register at offset 0x03C
package acmux_pkg;
  localparam logic [11:0] CSR_OFFSET = 12'h03C;
  localparam logic [31:0] CSR_RESET = 32'h00000000;
  localparam logic [31:0] CSR_WMASK = 32'hBFFFFFEF;
  localparam int LOCK_BIT = 31;
  localparam int CALOUT_BIT = 30;
  localparam int REFOUT_BIT = 29;
  localparam int NTRIM_LSB = 24;
  localparam int PTRIM_LSB = 19;
  localparam int UTRIM_BIT = 18;
  localparam int GAIN_LSB = 14;
  localparam int CAL_REFERENCE_SELECT_LSB = 12;
  localparam int CAL_MODE_ENABLE_BIT = 11;
  localparam int SNI_LSB = 9;
  localparam int SINV_BIT = 8;
  localparam int TMUX_BIT = 7;
  localparam int PINV_LSB = 5;
  localparam int PNI_LSB = 2;
  localparam int FORCE_BIT = 1;
  localparam int EN_BIT = 0;

  typedef struct packed {
    logic [31:0] csr;
    logic pready;
    logic pslverr;
    logic [31:0] prdata;
    logic [1:0] noninvSel;
    logic [1:0] invSel;
    logic [1:0] gain;
    logic [1:0] fbPin;
    logic [4:0] nTrim;
    logic [4:0] pTrim;
    logic [1:0] refLevel;
    logic calBoth;
    logic forceNi;
    logic refOutEn;
    logic ampOn;
  } acmux_state_t;
endpackage : acmux_pkg

// [acmux_ctrl.sv]
// amplifier control register with timer driven input multiplexing
module acmux_ctrl (
  input wire logic core_clk,
  input wire logic sys_rst,
  input wire logic clkEn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic pready,
  output logic [31:0] prdata,
  output logic pslverr,
  input wire logic timerCompareSixOutput,
  input wire logic calCompareIn,
  output logic [1:0] noninvSel,
  output logic [1:0] invSel,
  output logic [1:0] gainSel,
  output logic [1:0] feedbackPin,
  output logic [4:0] nmosTrim,
  output logic [4:0] pmosTrim,
  output logic [1:0] calReferenceSelect,
  output logic calBothInputs,
  output logic forceReferenceNoninv,
  output logic referenceOutputOn,
  output logic amplifierEnable
);
  acmux_pkg::acmux_state_t state_ff;
  acmux_pkg::acmux_state_t nxt_state;
  logic [31:0] strbMask;
  logic [31:0] wrMask;
  logic [31:0] csrView;
  logic useSecondary;
  logic hit;

  always_comb
  begin
    nxt_state = state_ff;
    strbMask = {{8{pstrb[3]}}, {8{pstrb[2]}}, {8{pstrb[1]}}, {8{pstrb[0]}}};
    hit = (paddr == acmux_pkg::CSR_OFFSET);
    csrView = state_ff.csr;
    csrView[acmux_pkg::CALOUT_BIT] = calCompareIn;
    wrMask = acmux_pkg::CSR_WMASK & strbMask;
    nxt_state.pready = 1'b0;
    nxt_state.pslverr = 1'b0;
    if (psel && !penable)
    begin
      nxt_state.pready = 1'b1;
      nxt_state.pslverr = !hit;
      nxt_state.prdata = (hit && !pwrite) ? csrView : 32'h00000000;
    end
    // write lands only at the edge where the master samples pready high
    if (psel && penable && state_ff.pready && hit && pwrite
        && !state_ff.csr[acmux_pkg::LOCK_BIT])
    begin
      nxt_state.csr = (state_ff.csr & ~wrMask) | (pwdata & wrMask);
    end
    useSecondary = state_ff.csr[acmux_pkg::TMUX_BIT] && timerCompareSixOutput;
    if (useSecondary)
    begin
      nxt_state.noninvSel = state_ff.csr[acmux_pkg::SNI_LSB +: 2];
      nxt_state.invSel = {1'b0, state_ff.csr[acmux_pkg::SINV_BIT]};
    end
    else
    begin
      nxt_state.noninvSel = state_ff.csr[acmux_pkg::PNI_LSB +: 2];
      nxt_state.invSel = state_ff.csr[acmux_pkg::PINV_LSB +: 2];
    end
    nxt_state.gain = state_ff.csr[acmux_pkg::GAIN_LSB +: 2];
    if (state_ff.csr[acmux_pkg::GAIN_LSB + 3])
      nxt_state.fbPin = state_ff.csr[acmux_pkg::GAIN_LSB + 2] ? 2'h2 : 2'h1;
    else
      nxt_state.fbPin = 2'h0;
    nxt_state.nTrim = state_ff.csr[acmux_pkg::UTRIM_BIT] ?
      state_ff.csr[acmux_pkg::NTRIM_LSB +: 5] : 5'h00;
    nxt_state.pTrim = state_ff.csr[acmux_pkg::UTRIM_BIT] ?
      state_ff.csr[acmux_pkg::PTRIM_LSB +: 5] : 5'h00;
    nxt_state.refLevel = state_ff.csr[acmux_pkg::CAL_REFERENCE_SELECT_LSB +: 2];
    nxt_state.calBoth = state_ff.csr[acmux_pkg::CAL_MODE_ENABLE_BIT];
    nxt_state.forceNi = state_ff.csr[acmux_pkg::FORCE_BIT];
    nxt_state.refOutEn = !state_ff.csr[acmux_pkg::REFOUT_BIT];
    nxt_state.ampOn = state_ff.csr[acmux_pkg::EN_BIT];
  end

  always_ff @(posedge core_clk)
  begin
    if (sys_rst)
      state_ff <= '0;
    else if (clkEn)
      state_ff <= nxt_state;
  end

  assign pready = state_ff.pready;
  assign prdata = state_ff.prdata;
  assign pslverr = state_ff.pslverr;
  assign noninvSel = state_ff.noninvSel;
  assign invSel = state_ff.invSel;
  assign gainSel = state_ff.gain;
  assign feedbackPin = state_ff.fbPin;
  assign nmosTrim = state_ff.nTrim;
  assign pmosTrim = state_ff.pTrim;
  assign calReferenceSelect = state_ff.refLevel;
  assign calBothInputs = state_ff.calBoth;
  assign forceReferenceNoninv = state_ff.forceNi;
  assign referenceOutputOn = state_ff.refOutEn;
  assign amplifierEnable = state_ff.ampOn;

  lock_holds_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    $past(state_ff.csr[31]) && $past(clkEn) |-> state_ff.csr == $past(state_ff.csr))
    else $error("locked register changed");
  secondary_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && state_ff.csr[7] && timerCompareSixOutput |=> noninvSel == $past(state_ff.csr[10:9]))
    else $error("secondary selection not applied");
  primary_sel_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && !state_ff.csr[7] |=> invSel == $past(state_ff.csr[6:5]))
    else $error("primary selection not applied");
  trim_gate_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && !state_ff.csr[18] |=> nmosTrim == 5'h00 && pmosTrim == 5'h00)
    else $error("trim applied while user trim off");
  feedback_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && state_ff.csr[17:16] == 2'h3 |=> feedbackPin == 2'h2)
    else $error("feedback routing wrong");
  refout_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn |=> referenceOutputOn == !$past(state_ff.csr[29]))
    else $error("reference output polarity wrong");
  calout_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn && psel && !penable && !pwrite && paddr == 12'h03C |=> prdata[30] == $past(calCompareIn))
    else $error("comparator status not read back");
  enable_a: assert property (@(posedge core_clk) disable iff (sys_rst)
    clkEn |=> amplifierEnable == $past(state_ff.csr[0]))
    else $error("enable does not follow register");
endmodule : acmux_ctrl

// [acmux_timer_model.sv]
// timer compare channel model that toggles the mux trigger
module acmux_timer_model #(parameter int HALF = 6) (
  input wire logic core_clk,
  output logic timerCompareSixOutput = 1'h0
);
  timeunit 1ns;
  timeprecision 1ns;
  int cnt = 0;
  always @(posedge core_clk)
  begin
    cnt <= (cnt == HALF - 1) ? 0 : cnt + 1;
    if (cnt == HALF - 1)
      timerCompareSixOutput <= ~timerCompareSixOutput;
  end
endmodule : acmux_timer_model

// [acmux_ctrl_test.sv]
// self-checking bench for the amplifier control register
module acmux_ctrl_test;
  timeunit 1ns;
  timeprecision 1ns;
  localparam logic [11:0] A = acmux_pkg::CSR_OFFSET;
  logic core_clk = 0, sys_rst = 1, psel = 0, penable = 0, pwrite = 0, calIn = 0;
  logic pready, pslverr, trig, calBoth, forceNi, refOn, ampOn;
  logic [11:0] paddr = 12'h0;
  logic [31:0] pwdata = 32'h0, prdata, d;
  logic [1:0] niSel, invSel, gainSel, fbPin, calRef;
  logic [4:0] nTrim, pTrim;
  logic [32:0] expQ[$];
  int bad_count = 0, total_checks = 0, seed = 32'h3d8a, i;
  acmux_timer_model acmux_timer_model_i (.core_clk(core_clk), .timerCompareSixOutput(trig));
  acmux_ctrl acmux_ctrl_i (.core_clk(core_clk), .sys_rst(sys_rst), .clkEn(1'h1), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pstrb(4'hF),
    .pready(pready), .prdata(prdata), .pslverr(pslverr), .timerCompareSixOutput(trig),
    .calCompareIn(calIn), .noninvSel(niSel), .invSel(invSel), .gainSel(gainSel),
    .feedbackPin(fbPin), .nmosTrim(nTrim), .pmosTrim(pTrim), .calReferenceSelect(calRef),
    .calBothInputs(calBoth), .forceReferenceNoninv(forceNi), .referenceOutputOn(refOn),
    .amplifierEnable(ampOn));
  initial forever #50 core_clk = ~core_clk;
  task automatic conclude();
    if (bad_count == 0 && total_checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : conclude
  task automatic hang();
    bad_count++;
    conclude();
  endtask : hang
  task automatic chk(input string n, input logic [32:0] s, input logic [32:0] x);
    total_checks++;
    if (s !== x)
    begin
      bad_count++;
      $display("unexpected %s: expected %h seen %h", n, x, s);
    end
  endtask : chk
  task automatic wr(input logic w, input logic [11:0] a, input logic [31:0] v);
    int n;
    @(posedge core_clk);
    psel <= 1'h1;
    pwrite <= w;
    paddr <= a;
    pwdata <= v;
    @(posedge core_clk);
    penable <= 1'h1;
    n = 0;
    do @(posedge core_clk); while (pready !== 1'h1 && ++n < 20);
    if (n == 20) hang();
    psel <= 1'h0;
    penable <= 1'h0;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] x, input logic e);
    expQ.push_back({e, x});
    wr(1'h0, a, 32'h0);
  endtask : rd
  task automatic tw(input logic l, input logic [3:0] x);
    int n;
    n = 0;
    do @(posedge core_clk); while (trig !== l && ++n < 40);
    if (n == 40) hang();
    @(posedge core_clk);
    chk("mux", {niSel, invSel}, x);
  endtask : tw
  task automatic rst();
    sys_rst <= 1'h1;
    repeat (3) @(posedge core_clk);
    sys_rst <= 1'h0;
  endtask : rst
  always @(posedge core_clk)
    if (pready === 1'h1 && !pwrite) chk("csr", {pslverr, prdata}, expQ.pop_front());
  initial
  begin
    rst();
    rd(A, 32'h0, 1'h0);
    chk("refOn", refOn, 1'h1);
    for (i = 0; i < 4; i++)
    begin
      d = $random(seed) & 32'h7FFFFF6F;
      calIn <= ~d[30];
      wr(1'h1, A, d);
      repeat (2) @(negedge core_clk);
      chk("nTrim", nTrim, d[18] ? d[28:24] : 5'h0);
      chk("pTrim", pTrim, d[18] ? d[23:19] : 5'h0);
      chk("cal", {calRef, calBoth, forceNi, ampOn}, {d[13:11], d[1:0]});
      chk("sel", {niSel, invSel, refOn}, {d[3:2], d[6:5], ~d[29]});
      rd(A, d ^ 32'h40000000, 1'h0);
    end
    for (i = 0; i < 16; i++)
    begin
      wr(1'h1, A, 32'h20000001 | (i << 14));
      repeat (2) @(negedge core_clk);
      chk("gain", {fbPin, gainSel}, {i[3] ? (i[2] ? 2'h2 : 2'h1) : 2'h0, i[1:0]});
    end
    wr(1'h1, A, 32'h00000504);
    tw(1'h1, 4'h4);
    wr(1'h1, A, 32'h00000584);
    tw(1'h1, 4'h9);
    tw(1'h0, 4'h4);
    rd(12'h040, 32'h0, 1'h1);
    calIn <= 1'h1;
    wr(1'h1, A, 32'h80000001);
    wr(1'h1, A, 32'h00000F00);
    rd(A, 32'hC0000001, 1'h0);
    rst();
    rd(A, 32'h40000000, 1'h0);
    conclude();
  end
endmodule : acmux_ctrl_test
